// >>> rtl/cra_action.sv
`timescale 1ns/1ps
module cra_action
  import cra_pkg::*;
(
  input  wire logic       hclk,      // Core clock
  input  wire logic       hresetn,   // Async reset
  input  wire logic       fire,      // Event this cycle
  input  wire logic [2:0] event_action,      // Action code
  input  wire logic       breakout_disable,       // Break-out disable
  input  wire logic       break_before_make_select,       // Break before make
  output logic            bo_q,      // Break-out pulse
  output logic [5:0]      act_q      // {bint[3:0], trap, halt}
);

  logic [5:0] late_act_q;
  logic       late_bo_q;

  wire        halt_w = (event_action == CRA_ACT_HALT);
  wire        trap_w = (event_action == CRA_ACT_TRAP);
  // Codes 4..7 map to interrupts 0..3; missing ones do nothing
  wire  [3:0] bint_w = event_action[2] ? ((4'h1 << event_action[1:0]) & CRA_BINT_IMPL)
                               : 4'h0;                                // [RQ11] [RQ12] [RQ13]
  wire  [5:0] act_w  = {bint_w, trap_w, halt_w};                      // [RQ9] [RQ10]
  wire        any_w  = |act_w;
  // Unimplemented interrupt codes give no pulse either
  wire        bo_w   = !breakout_disable && (event_action == CRA_ACT_PULSE || any_w);      // [RQ5] [RQ6] [RQ8]
  wire        split  = bo_w && any_w;
  // Ordering only matters when both a pulse and an action occur
  wire  [5:0] now_act  = (fire && !(split && break_before_make_select)) ? act_w : 6'h00;   // [RQ7]
  wire  [5:0] late_act = (fire && split && break_before_make_select) ? act_w : 6'h00;      // [RQ7]
  wire        now_bo   = fire && bo_w && !(split && !break_before_make_select);            // [RQ7]
  wire        late_bo  = fire && split && !break_before_make_select;                       // [RQ7]

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      act_q      <= 6'h00;
      late_act_q <= 6'h00;
      bo_q       <= 1'b0;
      late_bo_q  <= 1'b0;
    end
    else
    begin
      act_q      <= now_act | late_act_q;
      late_act_q <= late_act;
      bo_q       <= now_bo | late_bo_q;
      late_bo_q  <= late_bo;
    end
  end

endmodule // cra_action

// >>> rtl/cra_event_top.sv
// Contract
// [RQ1] Counter code 00 leaves counters alone
// [RQ2] Code 01 starts, 10 stops counters
// [RQ3] Code 11 toggles counter run state
// [RQ4] Suspend-out takes stored bit on event
// [RQ5] Break-out pulses per action when enabled
// [RQ6] Disable bit suppresses break-out, actions remain
// [RQ7] Select bit orders break versus make
// [RQ8] Action code 000 does nothing
// [RQ9] 001 pulses only; 010 halts and pulses
// [RQ10] 011 takes breakpoint trap and pulses
// [RQ11] 100 raises breakpoint interrupt 0
// [RQ12] 101..111 raise interrupts 1..3 if present
// [RQ13] Absent interrupts give no action
// [RQ14] Matching special register access raises event
`timescale 1ns/1ps
module cra_event_top
  import cra_pkg::*;
(
  input  wire logic        hclk,            // Core clock, 250 MHz
  input  wire logic        hresetn,         // Async reset
  input  wire logic        hsel,            // Slave select
  input  wire logic [31:0] haddr,           // Byte address
  input  wire logic [1:0]  htrans,          // Transfer type
  input  wire logic        hwrite,          // Write
  input  wire logic [2:0]  hsize,           // Word only
  input  wire logic [31:0] hwdata,          // Write data
  input  wire logic        hready,          // Bus ready
  output logic             hreadyout,       // Slave ready
  output logic             hresp,           // Always OKAY
  output logic [31:0]      hrdata,          // Read data
  input  wire logic        sfr_acc_valid,   // Core SFR access
  input  wire logic [15:0] sfr_acc_addr,    // Its address
  output logic             perf_cnt_run,    // Counters running
  output logic             suspend_out,     // Suspend-out level
  output logic             break_out_signal,// Break-out pulse
  output logic             break_before_make,// Ordering select
  output logic             halt_req,        // Halt pulse
  output logic             bkpt_trap_req,   // Trap pulse
  output logic [3:0]       bkpt_int_req,    // Interrupt pulses
  output logic             irq              // Status interrupt
);

  function automatic logic hit(input logic [CRA_AW-1:0] a,
                               input logic [CRA_AW-1:0] ofs);
    hit = (a == ofs);
  endfunction

  logic [CRA_CFG_W-1:0] cfg_q;
  logic [16:0]          match_q;
  logic [CRA_STS_W-1:0] sts_q;
  logic [CRA_STS_W-1:0] mask_q;
  logic                 run_q;
  logic                 suspend_out_value_q;
  logic                 wr_q;
  logic                 rd_q;
  logic [CRA_AW-1:0]    addr_q;
  logic                 rdy_q;
  logic                 resp_q;
  logic [31:0]          rdata_q;
  logic                 irq_q;
  logic                 bo_q;
  logic [5:0]           act_q;

  // Bus address phase
  wire addr_ok = hsel && hready && htrans[1];
  wire wr_cfg   = wr_q && hit(addr_q, CRA_OFS_CFG);
  wire wr_match = wr_q && hit(addr_q, CRA_OFS_MATCH);
  wire wr_sts   = wr_q && hit(addr_q, CRA_OFS_STS);
  wire wr_mask  = wr_q && hit(addr_q, CRA_OFS_MASK);
  wire wr_state = wr_q && hit(addr_q, CRA_OFS_STATE);

  // Config fields
  wire [1:0] cnt  = cfg_q[CRA_CNT_LSB +: 2];
  wire       suspend_out_value = cfg_q[CRA_SUSPEND_OUT_VALUE_BIT];
  wire       breakout_disable  = cfg_q[CRA_BOD_BIT];
  wire       break_before_make_select  = cfg_q[CRA_BBM_BIT];
  wire [2:0] event_action = cfg_q[CRA_EVENT_ACTION_LSB +: 3];

  // Event source
  wire fire = sfr_acc_valid && match_q[CRA_MEN_BIT]
              && (sfr_acc_addr == match_q[15:0]);                     // [RQ14]

  // Counter run control; an event outranks a software write
  logic run_d;
  always_comb
  begin
    run_d = wr_state ? hwdata[0] : run_q;
    if (fire)
    begin
      case (cra_cnt_e'(cnt))
        CRA_CNT_KEEP:   run_d = run_q;                                // [RQ1]
        CRA_CNT_START:  run_d = 1'b1;                                 // [RQ2]
        CRA_CNT_STOP:   run_d = 1'b0;                                 // [RQ2]
        CRA_CNT_TOGGLE: run_d = ~run_q;                               // [RQ3]
        default:        run_d = run_q;
      endcase
    end
  end

  wire suspend_out_value_d = fire ? suspend_out_value : suspend_out_value_q;                                 // [RQ4]

  // Sticky status; a new event beats a same-cycle clear
  wire [CRA_STS_W-1:0] sts_set = {|act_q[5:2], act_q[1], act_q[0], fire};
  wire [CRA_STS_W-1:0] sts_clr = wr_sts ? hwdata[CRA_STS_W-1:0] : 4'h0;
  wire [CRA_STS_W-1:0] sts_d   = (sts_q & ~sts_clr) | sts_set;
  wire                 irq_d   = |(sts_d & mask_q);

  // Reserved bits read as zero
  wire [31:0] rdata_mux =
      hit(addr_q, CRA_OFS_CFG)   ? {24'h000000, cfg_q} :
      hit(addr_q, CRA_OFS_MATCH) ? {15'h0000, match_q} :
      hit(addr_q, CRA_OFS_STS)   ? {28'h0000000, sts_q} :
      hit(addr_q, CRA_OFS_MASK)  ? {28'h0000000, mask_q} :
      hit(addr_q, CRA_OFS_STATE) ? {30'h00000000, suspend_out_value_q, run_q} :
                                   32'h00000000;

  // Bus slave: writes take no wait, reads one wait state
  // so a read right after a write sees the new value
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      addr_q  <= 16'h0000;
      rdy_q   <= 1'b1;
      resp_q  <= 1'b0;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      wr_q   <= addr_ok && hwrite;
      rd_q   <= addr_ok && !hwrite;
      rdy_q  <= !(addr_ok && !hwrite);
      resp_q <= 1'b0;
      if (addr_ok)
        addr_q <= haddr[CRA_AW-1:0];
      if (rd_q)
        rdata_q <= rdata_mux;
    end
  end

  // Register file
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_q   <= CRA_CFG_RST;
      match_q <= CRA_MATCH_RST;
      mask_q  <= CRA_STS_RST;
    end
    else
    begin
      if (wr_cfg)
        cfg_q <= hwdata[CRA_CFG_W-1:0];                               // [RQ14]
      if (wr_match)
        match_q <= hwdata[16:0];
      if (wr_mask)
        mask_q <= hwdata[CRA_STS_W-1:0];
    end
  end

  // Block state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_q  <= 1'b0;
      suspend_out_value_q <= 1'b0;
      sts_q  <= CRA_STS_RST;
      irq_q  <= 1'b0;
    end
    else
    begin
      run_q  <= run_d;
      suspend_out_value_q <= suspend_out_value_d;
      sts_q  <= sts_d;
      irq_q  <= irq_d;
    end
  end

  cra_action u_action (
    .hclk    (hclk),
    .hresetn (hresetn),
    .fire    (fire),
    .event_action    (event_action),
    .breakout_disable     (breakout_disable),
    .break_before_make_select     (break_before_make_select),
    .bo_q    (bo_q),
    .act_q   (act_q)
  );

  assign hreadyout         = rdy_q;
  assign hresp             = resp_q;
  assign hrdata            = rdata_q;
  assign perf_cnt_run      = run_q;
  assign suspend_out       = suspend_out_value_q;
  assign break_out_signal  = bo_q;
  assign break_before_make = cfg_q[CRA_BBM_BIT];                      // [RQ7]
  assign halt_req          = act_q[0];
  assign bkpt_trap_req     = act_q[1];
  assign bkpt_int_req      = act_q[5:2];
  assign irq               = irq_q;

  // Helper terms for checking
  wire bo_en     = !breakout_disable && (event_action == CRA_ACT_PULSE || event_action == CRA_ACT_HALT
                   || event_action == CRA_ACT_TRAP || event_action == CRA_ACT_BINT0);
  wire f_bo      = fire && bo_en;
  wire f_halt    = fire && event_action == CRA_ACT_HALT;
  wire f_trap    = fire && event_action == CRA_ACT_TRAP;
  wire f_bint0   = fire && event_action == CRA_ACT_BINT0;
  wire f_hi      = fire && event_action[2] && (event_action[1:0] != 2'b00);
  wire f_bbm     = f_halt && !breakout_disable && break_before_make_select;
  wire f_bam     = f_halt && !breakout_disable && !break_before_make_select;
  wire bo_src    = bo_en && fire;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_break_then_halt;
    break_out_signal && !halt_req ##1 halt_req && !break_out_signal;
  endsequence

  sequence s_halt_then_break;
    halt_req && !break_out_signal ##1 break_out_signal && !halt_req;
  endsequence

  a_cnt_keep: assert property ( // [RQ1]
    fire && cnt == 2'b00 && !wr_state |=> perf_cnt_run == $past(perf_cnt_run))
    else $error("Counter run changed with keep code");

  a_cnt_start: assert property ( // [RQ2]
    fire && cnt == 2'b01 |=> perf_cnt_run)
    else $error("Counters not started");

  a_cnt_stop: assert property ( // [RQ2]
    fire && cnt == 2'b10 |=> !perf_cnt_run)
    else $error("Counters not stopped");

  a_cnt_toggle: assert property ( // [RQ3]
    fire && cnt == 2'b11 |=> perf_cnt_run != $past(perf_cnt_run))
    else $error("Counter run not toggled");

  a_suspend_out_value_value: assert property ( // [RQ4]
    fire |=> suspend_out == $past(suspend_out_value))
    else $error("Suspend-out not loaded on event");

  a_suspend_out_value_hold: assert property ( // [RQ4]
    !fire |=> $stable(suspend_out))
    else $error("Suspend-out moved without event");

  a_bo_source: assert property ( // [RQ5]
    break_out_signal |-> $past(bo_src, 1) || $past(bo_src, 2))
    else $error("Break-out without enabled event");

  a_bo_enabled: assert property ( // [RQ5]
    f_bo |-> ##[1:2] break_out_signal)
    else $error("Break-out pulse missing");

  a_bo_disabled: assert property ( // [RQ6]
    fire && breakout_disable && event_action == CRA_ACT_HALT && !$past(fire)
    |-> ##1 (!break_out_signal && halt_req) ##1 !break_out_signal)
    else $error("Break-out pulsed while disabled");

  a_bbm_order: assert property ( // [RQ7]
    f_bbm && !$past(fire) |=> s_break_then_halt)
    else $error("Break before make order wrong");

  a_bam_order: assert property ( // [RQ7]
    f_bam && !$past(fire) |=> s_halt_then_break)
    else $error("Break after make order wrong");

  a_act_off: assert property ( // [RQ8]
    fire && event_action == CRA_ACT_OFF && !$past(fire)
    |=> (act_q == 6'h00 && !break_out_signal)[*2])
    else $error("Disabled action had an effect");

  a_halt_cause: assert property ( // [RQ9]
    halt_req |-> $past(f_halt, 1) || $past(f_halt, 2))
    else $error("Halt without halt event");

  a_halt_issue: assert property ( // [RQ9]
    f_halt |-> ##[1:2] halt_req)
    else $error("Halt not issued");

  a_trap_issue: assert property ( // [RQ10]
    f_trap |-> ##[1:2] bkpt_trap_req)
    else $error("Breakpoint trap not issued");

  a_trap_cause: assert property ( // [RQ10]
    bkpt_trap_req |-> $past(f_trap, 1) || $past(f_trap, 2))
    else $error("Trap without trap event");

  a_bint0_issue: assert property ( // [RQ11]
    f_bint0 |-> ##[1:2] bkpt_int_req[0])
    else $error("Breakpoint interrupt 0 not raised");

  a_bint_high: assert property ( // [RQ12]
    bkpt_int_req[3:1] != 3'b000 |-> $past(f_hi, 1) || $past(f_hi, 2))
    else $error("High interrupt without its code");

  a_bint_absent: assert property ( // [RQ13]
    (bkpt_int_req & ~CRA_BINT_IMPL) == 4'h0)
    else $error("Unimplemented interrupt raised");

  a_fire_status: assert property ( // [RQ14]
    fire |=> sts_q[CRA_STS_EVT])
    else $error("Event status not set");

  a_irq_level: assert property (
    irq |-> $past(|(sts_d & mask_q)))
    else $error("Interrupt without unmasked status");

  a_bo_blocked: assert property ( // [RQ6]
    break_out_signal |-> $past(fire && !breakout_disable, 1) || $past(fire && !breakout_disable, 2))
    else $error("Break-out pulsed while disabled");

  // Only a one written to the bit may drop it
  a_sts_sticky: assert property (
    sts_q[CRA_STS_EVT] && !(wr_sts && hwdata[CRA_STS_EVT]) |=> sts_q[CRA_STS_EVT])
    else $error("Event status lost without clear");

  // Mask writes take effect one cycle late on the interrupt
  a_irq_cause: assert property (
    irq && !$past(wr_mask) |-> |(sts_q & mask_q))
    else $error("Interrupt with no unmasked status");

  a_irq_follow: assert property (
    (|(sts_q & mask_q)) && !wr_sts |=> irq)
    else $error("Unmasked status gave no interrupt");

  a_rd_wait: assert property (
    addr_ok && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("Read wait state wrong");

  a_resp_okay: assert property (
    !hresp)
    else $error("Error response given");

  a_rsvd_zero: assert property ( // [RQ14]
    rd_q && hit(addr_q, CRA_OFS_CFG) |=> hrdata[31:CRA_CFG_W] == 24'h000000)
    else $error("Reserved config bits read nonzero");

  a_run_write: assert property (
    wr_state && !fire |=> perf_cnt_run == $past(hwdata[0]))
    else $error("Counter run write lost");

endmodule // cra_event_top

// >>> rtl/cra_pkg.sv
package cra_pkg;

  localparam int unsigned CRA_AW = 16;

  // Register byte offsets
  localparam logic [CRA_AW-1:0] CRA_OFS_CFG   = 16'hfd0c;
  localparam logic [CRA_AW-1:0] CRA_OFS_MATCH = 16'hfd40;
  localparam logic [CRA_AW-1:0] CRA_OFS_STS   = 16'hfd44;
  localparam logic [CRA_AW-1:0] CRA_OFS_MASK  = 16'hfd48;
  localparam logic [CRA_AW-1:0] CRA_OFS_STATE = 16'hfd4c;

  // Config fields
  localparam int unsigned CRA_CNT_LSB  = 6;
  localparam int unsigned CRA_SUSPEND_OUT_VALUE_BIT = 5;
  localparam int unsigned CRA_BOD_BIT  = 4;
  localparam int unsigned CRA_BBM_BIT  = 3;
  localparam int unsigned CRA_EVENT_ACTION_LSB = 0;
  localparam int unsigned CRA_CFG_W    = 8;
  localparam logic [CRA_CFG_W-1:0] CRA_CFG_RST = 8'h00;

  // Match register: compare address in [15:0], enable in bit 16
  localparam int unsigned CRA_MEN_BIT = 16;
  localparam logic [16:0] CRA_MATCH_RST = 17'h00000;

  // Status / mask bits
  localparam int unsigned CRA_STS_W     = 4;
  localparam int unsigned CRA_STS_EVT   = 0;
  localparam int unsigned CRA_STS_HALT  = 1;
  localparam int unsigned CRA_STS_TRAP  = 2;
  localparam int unsigned CRA_STS_BINT  = 3;
  localparam logic [CRA_STS_W-1:0] CRA_STS_RST = 4'h0;

  // Breakpoint interrupts that exist in this core
  localparam logic [3:0] CRA_BINT_IMPL = 4'h1;

  typedef enum logic [1:0] {
    CRA_CNT_KEEP,
    CRA_CNT_START,
    CRA_CNT_STOP,
    CRA_CNT_TOGGLE
  } cra_cnt_e;

  typedef enum logic [2:0] {
    CRA_ACT_OFF,
    CRA_ACT_PULSE,
    CRA_ACT_HALT,
    CRA_ACT_TRAP,
    CRA_ACT_BINT0,
    CRA_ACT_BINT1,
    CRA_ACT_BINT2,
    CRA_ACT_BINT3
  } cra_act_e;

endpackage

// >>> tb/cra_core_model.sv
`timescale 1ns/1ps
module cra_core_model
  import cra_pkg::*;
(
  input  wire logic        hclk,          // Core clock
  output logic             sfr_acc_valid, // Access strobe
  output logic [15:0]      sfr_acc_addr   // Access address
);
  initial
  begin
    sfr_acc_valid = 1'b0;
    sfr_acc_addr  = 16'h0000;
  end

  // Address churns while idle so a stale match cannot pass
  task automatic access(input logic [15:0] a, input int unsigned gap);
    repeat (gap)
    begin
      @(posedge hclk);
      sfr_acc_addr <= ~sfr_acc_addr;
    end
    sfr_acc_valid <= 1'b1;
    sfr_acc_addr  <= a;
    @(posedge hclk);
    sfr_acc_valid <= 1'b0;
    sfr_acc_addr  <= ~a;
  endtask
endmodule // cra_core_model

// >>> tb/cra_event_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cra_event_top_tb;
  import cra_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rdy, irq;
  logic [31:0] haddr, hwdata, hrdata, hrd, rd_val, r, rexp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        sfr_acc_valid, perf_cnt_run, suspend_out, brk, bbm_o, halt, trap;
  logic [15:0] sfr_acc_addr, ma;
  logic [3:0]  bint;
  logic [6:0]  pv, pexp;
  logic [31:0] qr[$];
  logic [6:0]  qp[$];
  logic [1:0]  cseq[6] = '{2'd1, 2'd0, 2'd3, 2'd3, 2'd2, 2'd0};
  logic        run, su, breakout_disable;
  int          err_count, check_count;
  event        rd_ev;

  cra_event_top cra_event_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sfr_acc_valid(sfr_acc_valid), .sfr_acc_addr(sfr_acc_addr),
    .perf_cnt_run(perf_cnt_run), .suspend_out(suspend_out), .break_out_signal(brk),
    .break_before_make(bbm_o), .halt_req(halt), .bkpt_trap_req(trap),
    .bkpt_int_req(bint), .irq(irq));
  cra_core_model cra_core_model_inst (.hclk(hclk), .sfr_acc_valid(sfr_acc_valid),
    .sfr_acc_addr(sfr_acc_addr));

  always #2 hclk = ~hclk;
  // Registered outputs are settled mid-cycle
  always @(negedge hclk)
  begin
    rdy = hreadyout;
    hrd = hrdata;
  end
  assign pv = {brk, halt, trap, bint};

  always @(negedge hclk)
    if (hresetn === 1'b1 && pv !== 7'h00)
    begin
      pexp = (qp.size() > 0) ? qp.pop_front() : 7'h00;
      `CHK(pv, pexp)
    end
  initial forever
  begin
    @(rd_ev);
    rexp = qr.pop_front();
    `CHK(rd_val, rexp)
  end

  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {16'h0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (rdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (rdy !== 1'b1);
    r = hrd;
    `CHK(hresp, 1'b0)
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    qr.push_back(e);
    bus(1'b0, a, 32'h0);
    rd_val = r;
    ->rd_ev;
  endtask

  // Expected pulse order for one event
  function automatic void plan(input logic [2:0] c, input logic bd, input logic bb);
    logic [6:0] a, b;
    a = (c == 3'd2) ? 7'h20 : (c == 3'd3) ? 7'h10 : 7'h00;
    if (c >= 3'd4 && CRA_BINT_IMPL[c - 3'd4])
      a = 7'h01 << (c - 3'd4);
    b = (!bd && c != 3'd0 && (c < 3'd4 || a != 7'h00)) ? 7'h40 : 7'h00;
    if (a != 7'h00 && b != 7'h00)
    begin
      qp.push_back(bb ? b : a);
      qp.push_back(bb ? a : b);
    end
    else if ((a | b) != 7'h00)
      qp.push_back(a | b);
  endfunction

  task automatic fire(input logic [7:0] c, input logic [15:0] a);
    wr(CRA_OFS_CFG, {24'h0, c});
    cra_core_model_inst.access(a, $urandom % 4);
    repeat (4) @(posedge hclk);
    // Looked at well after the write edge that launched it
    `CHK(bbm_o, c[3])
    `CHK(qp.size(), 0)
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #200000;
    err_count++;
    conclude();
  end

  initial
  begin
    hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
    hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0; rdy = 1'b0;
    err_count = 0; check_count = 0;
    void'($urandom(58));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(CRA_OFS_CFG, 32'h0);
    rd(CRA_OFS_MATCH, 32'h0);
    rd(CRA_OFS_STS, 32'h0);
    rd(CRA_OFS_MASK, 32'h0);
    wr(CRA_OFS_CFG, 32'hffffffff);
    rd(CRA_OFS_CFG, 32'h000000ff);
    wr(16'hfd00, 32'h5a5a5a5a);
    rd(16'hfd00, 32'h0);
    done("registers");

    ma = 16'($urandom);
    wr(CRA_OFS_MATCH, {15'h0, 1'b1, ma});
    run = 1'b0;
    for (int k = 0; k < 6; k++)
    begin
      su = ~k[0];
      case (cseq[k])
        2'd1: run = 1'b1;
        2'd2: run = 1'b0;
        2'd3: run = ~run;
        default: ;
      endcase
      fire({cseq[k], su, 1'b1, 1'b0, 3'b000}, ma);
      `CHK(perf_cnt_run, run)
      `CHK(suspend_out, su)
      rd(CRA_OFS_STATE, {30'h0, su, run});
    end
    // Run bit is writable, suspend bit is not
    wr(CRA_OFS_STATE, 32'h00000003);
    rd(CRA_OFS_STATE, {30'h0, su, 1'b1});
    done("counters");

    for (int i = 0; i < 16; i++)
    begin
      breakout_disable = i[3];
      su = 1'($urandom);
      plan(i[2:0], breakout_disable, su);
      fire({3'b000, breakout_disable, su, i[2:0]}, ma);
    end
    done("actions");

    fire(8'h01, ma ^ 16'h0001);
    wr(CRA_OFS_MATCH, {16'h0, ma});
    fire(8'h01, ma);
    wr(CRA_OFS_MATCH, {15'h0, 1'b1, ma});
    plan(3'd1, 1'b0, 1'b0);
    fire(8'h01, ma);
    done("match");

    rd(CRA_OFS_STS, 32'h0000000f);
    `CHK(irq, 1'b0)
    wr(CRA_OFS_MASK, 32'h00000002);
    repeat (2) @(posedge hclk);
    `CHK(irq, 1'b1)
    wr(CRA_OFS_STS, 32'h00000002);
    repeat (2) @(posedge hclk);
    `CHK(irq, 1'b0)
    rd(CRA_OFS_STS, 32'h0000000d);
    plan(3'd2, 1'b1, 1'b0);
    fire(8'h12, ma);
    `CHK(irq, 1'b1)
    rd(CRA_OFS_MASK, 32'h00000002);
    done("interrupt");

    repeat (4) @(posedge hclk);
    `CHK(qr.size(), 0)
    conclude();
  end
endmodule // cra_event_top_tb
